// ---- bench/host_master.sv ----
// Behavioural I2C master standing in for the host processor.
// Assumes a pull-up on SDA: the wire reads high unless someone pulls.
`timescale 1ns/1ps
module host_master (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    localparam int HALF = 80;
    // Clock stands still high between frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // ------------------------------------------------------------
    // Bit and frame tasks
    // ------------------------------------------------------------
    task automatic bit_slot(input logic v, output logic r);
        scl = 1'b0;
        #(HALF/2) sda_pull = ~v;
        #(HALF/2) scl = 1'b1;
        #(HALF/2) r = sda;
        #(HALF/2);
    endtask
    task automatic start();
        sda_pull = 1'b1;
        #HALF;
    endtask
    // Idle gap after STOP leaves time for detection before the next START
    task automatic stop();
        scl = 1'b0;
        #(HALF/2) sda_pull = 1'b1;
        #(HALF/2) scl = 1'b1;
        #HALF sda_pull = 1'b0;
        #(2*HALF);
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], r);
        end
        bit_slot(1'b1, r);
        ack = ~r;
    endtask
    task automatic recv(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, b[i]);
        end
        bit_slot(last, r);
    endtask
endmodule

// ---- bench/regctl_props.sv ----
// Checker for the regulator control block, bound to its top module.
// Assumes SS_CYCLES matches the instance and the clk domain sees all pins.
`timescale 1ns/1ps
module regctl_props #(
    parameter int SS_CYCLES = 50
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       scl,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       enable_pin,
    input wire logic       set_choice_pin,
    input wire logic       ovp_detect,
    input wire logic       output_on,
    input wire logic       forced_pwm,
    input wire logic [5:0] voltage_code,
    input wire logic       discharge_en,
    input wire logic       power_ok_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    int         ovp_cnt;
    int         on_cnt;
    int         step_cnt;
    logic [5:0] code_q;
    logic       last_up;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovp_cnt <= 0;
            on_cnt <= 0;
        end else begin
            ovp_cnt <= ovp_detect ? ovp_cnt + 1 : 0;
            on_cnt <= output_on ? on_cnt + 1 : 0;
        end
    end
    // Only back-to-back rising steps are paced; a retarget may step at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_cnt <= 0;
            code_q <= 6'h17;
            last_up <= 1'b0;
        end else begin
            step_cnt <= (voltage_code != code_q) ? 0 : step_cnt + 1;
            code_q <= voltage_code;
            if (voltage_code != code_q) begin
                last_up <= voltage_code > code_q;
            end
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ovp_stop: assert property (ovp_cnt >= 2010 |-> !output_on && !power_ok_flag)
        else $error("switching kept on past over-voltage blanking");
    a_en_off: assert property (!enable_pin [*5] |-> !output_on)
        else $error("output on with enable pin low");
    a_power_ok_flag_off: assert property (!output_on [*3] |-> !power_ok_flag)
        else $error("power ok while output off");
    a_power_ok_flag_wait: assert property ($rose(power_ok_flag) |-> on_cnt >= SS_CYCLES - 3)
        else $error("power ok before soft-start done");
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("sda drive changed while scl high");
    a_open_drain: assert property (sda_o == 1'b0)
        else $error("sda driven high");
    a_code_step: assert property (voltage_code > $past(voltage_code)
        |-> voltage_code == $past(voltage_code) + 6'h01)
        else $error("rising code step larger than one");
    a_code_pace: assert property (voltage_code > code_q && last_up |-> step_cnt >= 14)
        else $error("rising code steps too close");
    a_reset_vals: assert property ($fell(rst) |-> discharge_en && voltage_code == 6'h17 && !output_on)
        else $error("wrong values after reset");
    c_power_ok_flag: cover property ($rose(power_ok_flag));
    c_ovp: cover property (ovp_cnt == 2010);
    c_ack: cover property ($rose(sda_oe));
endmodule

bind regulator_i2c_control_regs regctl_props #(.SS_CYCLES(SS_CYCLES)) u_props (.*);

// ---- bench/tb_top.sv ----
// Self-checking bench for the regulator control block.
// Assumes the host_master partner and the bound checker are compiled.
`timescale 1ns/1ps
module tb_top;
    import regctl_pkg::*;
    localparam int SS = 50;
    localparam logic [2:0] VC = 3'h5; // Arbitrary value
    localparam logic [3:0] OC = 4'h6; // Arbitrary value
    localparam logic [3:0] RV = 4'h9; // Arbitrary value
    logic       clk = 1'b0;
    logic       rst = 1'b0;
    logic       enable_pin = 1'b0;
    logic       set_choice_pin = 1'b0;
    logic       ovp_detect = 1'b0;
    logic       scl, sda_pull, sda_o, sda_oe, sda;
    logic       output_on, forced_pwm, discharge_en, power_ok_flag;
    logic [5:0] voltage_code;
    int         fail_count = 0;
    int         samples_checked = 0;
    always #5 clk = ~clk;
    assign sda = !(sda_pull || sda_oe);
    host_master m (.scl(scl), .sda_pull(sda_pull), .sda(sda));
    regulator_i2c_control_regs #(.VENDOR_CODE(VC), .OPTION_CODE(OC), .REVISION(RV), .SS_CYCLES(SS)) DUT (
        .clk(clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .enable_pin(enable_pin), .set_choice_pin(set_choice_pin), .ovp_detect(ovp_detect),
        .output_on(output_on), .forced_pwm(forced_pwm), .voltage_code(voltage_code),
        .discharge_en(discharge_en), .power_ok_flag(power_ok_flag));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] ad, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        m.start();
        m.send({ad, 1'b0}, a0);
        m.send(ptr, a1);
        m.send(d, a2);
        m.stop();
        ok = a0 & a1 & a2;
        cyc(6);
    endtask
    task automatic rd(input logic [7:0] exp);
        logic       a;
        logic [7:0] d;
        m.start();
        m.send({TARGET_ADDR, 1'b1}, a);
        m.recv(1'b1, d);
        m.stop();
        chk(8'(a), 8'h01);
        chk(d, exp);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_enable();
        chk(8'(voltage_code), 8'h17);
        chk(8'(discharge_en), 8'h01);
        rd(SET_RESET_VAL);
        enable_pin = 1'b1;
        cyc(6);
        chk(8'(output_on), 8'h01);
        chk(8'(power_ok_flag), 8'h00);
        cyc(SS + 5);
        chk(8'(power_ok_flag), 8'h01);
    endtask
    task automatic t_address();
        logic ok;
        wr(7'h42, OFS_SET_LOW, 8'h00, ok);
        chk(8'(ok), 8'h00);
        rd(SET_RESET_VAL);
        wr(TARGET_ADDR, OFS_SET_LOW, 8'hDA, ok);
        chk(8'(ok), 8'h01);
        cyc(100);
        chk(8'(forced_pwm), 8'h01);
        chk(8'(voltage_code), 8'h1A);
        rd(8'hDA);
    endtask
    // Slowest slew code: 15 << 6 cycles a step, falling jumps at once
    task automatic t_slew();
        logic ok;
        int   n;
        wr(TARGET_ADDR, OFS_CONTROL, 8'h7B, ok);
        chk(8'(discharge_en), 8'h00);
        rd(8'h70);
        wr(TARGET_ADDR, OFS_SET_LOW, 8'hDC, ok);
        n = 0;
        while (voltage_code === 6'h1A && n < 1100) begin
            cyc(1);
            n++;
        end
        chk(8'(voltage_code), 8'h1B);
        cyc(900);
        chk(8'(voltage_code), 8'h1B);
        cyc(200);
        chk(8'(voltage_code), 8'h1C);
        wr(TARGET_ADDR, OFS_SET_LOW, 8'hD0, ok);
        cyc(4);
        chk(8'(voltage_code), 8'h10);
    endtask
    task automatic t_select();
        logic ok;
        set_choice_pin = 1'b1;
        cyc(6);
        chk(8'(voltage_code), 8'h10);
        chk(8'(forced_pwm), 8'h00);
        wr(TARGET_ADDR, OFS_SET_HIGH, 8'h17, ok);
        cyc(4);
        chk(8'(output_on), 8'h00);
        chk(8'(power_ok_flag), 8'h00);
        set_choice_pin = 1'b0;
        cyc(6);
        chk(8'(output_on), 8'h01);
        chk(8'(voltage_code), 8'h10);
    endtask
    task automatic t_soft_reset();
        logic ok;
        wr(TARGET_ADDR, OFS_IDENT_FIRST, 8'hFF, ok);
        chk(8'(ok), 8'h01);
        rd({VC, 1'b0, OC});
        wr(TARGET_ADDR, OFS_IDENT_SECOND, 8'hFF, ok);
        rd({4'h0, RV});
        wr(TARGET_ADDR, OFS_POWER_GOOD, 8'hFF, ok);
        rd(8'h80);
        wr(TARGET_ADDR, 8'h06, 8'h00, ok);
        chk(8'(ok), 8'h01);
        rd(8'h00);
        wr(TARGET_ADDR, OFS_CONTROL, 8'h04, ok);
        cyc(120);
        chk(8'(discharge_en), 8'h01);
        chk(8'(voltage_code), 8'h17);
        rd(8'h80);
    endtask
    task automatic t_ovp_pin();
        cyc(SS + 10);
        ovp_detect = 1'b1;
        cyc(1900);
        chk(8'(output_on), 8'h01);
        cyc(150);
        chk(8'(output_on), 8'h00);
        chk(8'(power_ok_flag), 8'h00);
        ovp_detect = 1'b0;
        enable_pin = 1'b0;
        cyc(6);
        chk(8'(output_on), 8'h00);
    endtask
    // Reset rises after time zero so every asynchronous process sees it
    initial begin
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        cyc(5);
        t_reset_enable();
        t_address();
        t_slew();
        t_select();
        t_soft_reset();
        t_ovp_pin();
        end_sim();
    end
    // Whole run is near 126 us; a hang is cut off well beyond that
    initial begin
        #1_000_000;
        fail_count++;
        end_sim();
    end
endmodule

// ---- verilog/regctl_pkg.sv ----
// Constants, types and field layout for the regulator control registers.
// Assumes a 100 MHz system clock and an I2C link clocked by the SCL pin.
package regctl_pkg;

    // ------------------------------------------------------------
    // Addresses and register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] TARGET_ADDR      = 7'h41;
    localparam logic [7:0] OFS_SET_LOW      = 8'h00;
    localparam logic [7:0] OFS_SET_HIGH     = 8'h01;
    localparam logic [7:0] OFS_CONTROL      = 8'h02;
    localparam logic [7:0] OFS_IDENT_FIRST  = 8'h03;
    localparam logic [7:0] OFS_IDENT_SECOND = 8'h04;
    localparam logic [7:0] OFS_POWER_GOOD   = 8'h05;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         SET_ENABLE_BIT   = 7;
    localparam int         SET_PWM_BIT      = 6;
    localparam int         CTRL_DISCH_BIT   = 7;
    localparam int         CTRL_SLEW_LSB    = 4;
    localparam int         CTRL_RESET_BIT   = 2;
    localparam logic [7:0] SET_RESET_VAL    = 8'h97;
    localparam logic [0:0] DISCH_RESET_VAL  = 1'h1;
    localparam logic [2:0] SLEW_RESET_VAL   = 3'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 10;
    localparam int OVP_BLANK_NS   = 20000;
    localparam int OVP_BLANK_CYC  = OVP_BLANK_NS / CLK_PERIOD_NS;
    localparam int SOFT_START_NS  = 300000;
    localparam int SOFT_START_CYC = SOFT_START_NS / CLK_PERIOD_NS;
    localparam int STEP_BASE_NS   = 150;
    localparam int STEP_BASE_CYC  = (STEP_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_MAX_SHIFT = 6;

    typedef enum logic [3:0] {
        LK_ADDR     = 4'h0,
        LK_ACK_ADDR = 4'h1,
        LK_PTR      = 4'h2,
        LK_ACK_PTR  = 4'h3,
        LK_WDATA    = 4'h4,
        LK_ACK_W    = 4'h5,
        LK_RDATA    = 4'h6,
        LK_RACK     = 4'h7,
        LK_IGNORE   = 4'h8
    } link_state_t;

endpackage

// ---- verilog/regulator_i2c_control_regs.sv ----
// I2C target register bank and control logic of a step-down regulator.
// Assumes open-drain SDA resolved outside, SCL used as the link clock.
`timescale 1ns/1ps
module regulator_i2c_control_regs #(
    parameter logic [2:0] VENDOR_CODE = 3'h2, // Arbitrary value
    parameter logic [3:0] OPTION_CODE = 4'h3, // Arbitrary value
    parameter logic [3:0] REVISION    = 4'h2, // Arbitrary value
    parameter int         SS_CYCLES   = regctl_pkg::SOFT_START_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       scl,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    input  wire logic       enable_pin,
    input  wire logic       set_choice_pin,
    input  wire logic       ovp_detect,
    output logic            output_on,
    output logic            forced_pwm,
    output logic [5:0]      voltage_code,
    output logic            discharge_en,
    output logic            power_ok_flag
);
    import regctl_pkg::*;

    if (SS_CYCLES < 1) begin : g_chk
        $error("SS_CYCLES must be at least 1");
    end

    // ------------------------------------------------------------
    // Register storage (system clock)
    // ------------------------------------------------------------
    logic [7:0] set_low_reg;
    logic [7:0] set_high_reg;
    logic       disch_reg;
    logic [2:0] slew_reg;
    logic       power_ok_flag_reg;

    function automatic logic [7:0] reg_read(input logic [7:0] ofs,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi,
                                            input logic       dis,
                                            input logic [2:0] slw,
                                            input logic       pg);
        logic [7:0] v;
        v = 8'h00;
        case (ofs)
            OFS_SET_LOW:      v = lo;
            OFS_SET_HIGH:     v = hi;
            OFS_CONTROL:      v = {dis, slw, 4'h0};
            OFS_IDENT_FIRST:  v = {VENDOR_CODE, 1'b0, OPTION_CODE};
            OFS_IDENT_SECOND: v = {4'h0, REVISION};
            OFS_POWER_GOOD:   v = {pg, 7'h00};
            default:          v = 8'h00;
        endcase
        return v;
    endfunction

    // Ramp interval in cycles; codes above six saturate at the longest
    function automatic logic [10:0] step_cycles(input logic [2:0] code);
        logic [2:0] sh;
        sh = (code > 3'(STEP_MAX_SHIFT)) ? 3'(STEP_MAX_SHIFT) : code;
        return 11'(STEP_BASE_CYC) << sh;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic scl_a, scl_b, sda_a, sda_b, sda_c;
    logic en_a, en_b, sel_a, sel_b, ovp_a, ovp_b;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_a <= 1'b1;
            scl_b <= 1'b1;
            sda_a <= 1'b1;
            sda_b <= 1'b1;
            sda_c <= 1'b1;
            en_a  <= 1'b0;
            en_b  <= 1'b0;
            sel_a <= 1'b0;
            sel_b <= 1'b0;
            ovp_a <= 1'b0;
            ovp_b <= 1'b0;
        end else begin
            scl_a <= scl;
            scl_b <= scl_a;
            sda_a <= sda_i;
            sda_b <= sda_a;
            sda_c <= sda_b;
            en_a  <= enable_pin;
            en_b  <= en_a;
            sel_a <= set_choice_pin;
            sel_b <= sel_a;
            ovp_a <= ovp_detect;
            ovp_b <= ovp_a;
        end
    end

    // ------------------------------------------------------------
    // START / STOP detection
    // ------------------------------------------------------------
    // Either condition clears the link logic, so each frame starts clean
    logic frame_clr_reg;
    logic link_rst;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_clr_reg <= 1'b1;
        end else begin
            frame_clr_reg <= scl_b & (sda_c != sda_b);
        end
    end

    // Released while SCL is idle, so no link edge meets the release
    assign link_rst = rst | frame_clr_reg;

    // ------------------------------------------------------------
    // Link side (SCL clock)
    // ------------------------------------------------------------
    link_state_t lk_state_reg;
    logic [2:0]  bit_cnt_reg;
    logic [6:0]  shift_reg;
    logic        dir_read_reg;
    logic [7:0]  ptr_reg;
    logic [7:0]  tx_reg;
    logic [7:0]  wr_addr_reg;
    logic [7:0]  wr_data_reg;
    logic        wr_tog_reg;
    logic [7:0]  rx_byte;
    logic [7:0]  rd_word;

    assign rx_byte = {shift_reg, sda_i};
    // Read word is sampled from the other domain; only the power-ok bit
    // can move under it, and a single bit cannot tear
    assign rd_word = reg_read(ptr_reg, set_low_reg, set_high_reg,
                              disch_reg, slew_reg, power_ok_flag_reg);

    always_ff @(posedge scl or posedge link_rst) begin
        if (link_rst) begin
            lk_state_reg <= LK_ADDR;
            bit_cnt_reg  <= 3'h0;
            shift_reg    <= 7'h00;
            dir_read_reg <= 1'b0;
            tx_reg       <= 8'h00;
        end else begin
            shift_reg   <= rx_byte[6:0];
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            case (lk_state_reg)
                LK_ADDR: begin
                    if (bit_cnt_reg == 3'h7) begin
                        dir_read_reg <= sda_i;
                        if (shift_reg == TARGET_ADDR) begin
                            lk_state_reg <= LK_ACK_ADDR;
                        end else begin
                            lk_state_reg <= LK_IGNORE;
                        end
                    end
                end
                LK_ACK_ADDR: begin
                    bit_cnt_reg <= 3'h0;
                    if (dir_read_reg) begin
                        tx_reg       <= rd_word;
                        lk_state_reg <= LK_RDATA;
                    end else begin
                        lk_state_reg <= LK_PTR;
                    end
                end
                LK_PTR: begin
                    if (bit_cnt_reg == 3'h7) begin
                        lk_state_reg <= LK_ACK_PTR;
                    end
                end
                LK_ACK_PTR: begin
                    bit_cnt_reg  <= 3'h0;
                    lk_state_reg <= LK_WDATA;
                end
                LK_WDATA: begin
                    if (bit_cnt_reg == 3'h7) begin
                        lk_state_reg <= LK_ACK_W;
                    end
                end
                LK_ACK_W: begin
                    bit_cnt_reg  <= 3'h0;
                    lk_state_reg <= LK_WDATA;
                end
                LK_RDATA: begin
                    if (bit_cnt_reg == 3'h7) begin
                        lk_state_reg <= LK_RACK;
                    end
                end
                LK_RACK: begin
                    bit_cnt_reg <= 3'h0;
                    if (!sda_i) begin
                        tx_reg       <= rd_word;
                        lk_state_reg <= LK_RDATA;
                    end else begin
                        lk_state_reg <= LK_IGNORE;
                    end
                end
                LK_IGNORE: begin
                    lk_state_reg <= LK_IGNORE;
                end
                default: begin
                    lk_state_reg <= LK_IGNORE;
                end
            endcase
        end
    end

    // Pointer and write word live outside the frame reset: a read frame
    // answers from the last addressed register, and a STOP never moves
    // the toggle, which would replay a cleared word into the bank
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            ptr_reg     <= 8'h00;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            wr_tog_reg  <= 1'b0;
        end else if (lk_state_reg == LK_PTR && bit_cnt_reg == 3'h7) begin
            ptr_reg <= rx_byte;
        end else if (lk_state_reg == LK_WDATA && bit_cnt_reg == 3'h7) begin
            wr_addr_reg <= ptr_reg;
            wr_data_reg <= rx_byte;
            wr_tog_reg  <= ~wr_tog_reg;
        end
    end

    // SDA moves only on the falling SCL edge, never while SCL is high
    always_ff @(negedge scl or posedge link_rst) begin
        if (link_rst) begin
            sda_oe <= 1'b0;
        end else begin
            case (lk_state_reg)
                LK_ACK_ADDR: sda_oe <= 1'b1;
                LK_ACK_PTR:  sda_oe <= 1'b1;
                LK_ACK_W:    sda_oe <= 1'b1;
                LK_RDATA:    sda_oe <= ~tx_reg[3'h7 - bit_cnt_reg];
                default:     sda_oe <= 1'b0;
            endcase
        end
    end

    // Open-drain: the driven level is always low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Write transfer into the system clock domain
    // ------------------------------------------------------------
    logic wr_tog_a, wr_tog_b, wr_tog_c;
    logic wr_evt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_tog_a <= 1'b0;
            wr_tog_b <= 1'b0;
            wr_tog_c <= 1'b0;
        end else begin
            wr_tog_a <= wr_tog_reg;
            wr_tog_b <= wr_tog_a;
            wr_tog_c <= wr_tog_b;
        end
    end

    // Word is stable for a whole byte time after the toggle moves
    assign wr_evt = wr_tog_b ^ wr_tog_c;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            set_low_reg  <= SET_RESET_VAL;
            set_high_reg <= SET_RESET_VAL;
            disch_reg    <= DISCH_RESET_VAL;
            slew_reg     <= SLEW_RESET_VAL;
        end else if (wr_evt) begin
            case (wr_addr_reg)
                OFS_SET_LOW:  set_low_reg  <= wr_data_reg;
                OFS_SET_HIGH: set_high_reg <= wr_data_reg;
                OFS_CONTROL: begin
                    if (wr_data_reg[CTRL_RESET_BIT]) begin
                        set_low_reg  <= SET_RESET_VAL;
                        set_high_reg <= SET_RESET_VAL;
                        disch_reg    <= DISCH_RESET_VAL;
                        slew_reg     <= SLEW_RESET_VAL;
                    end else begin
                        disch_reg <= wr_data_reg[CTRL_DISCH_BIT];
                        slew_reg  <= wr_data_reg[CTRL_SLEW_LSB +: 3];
                    end
                end
                default: set_low_reg <= set_low_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Active set and enable
    // ------------------------------------------------------------
    logic [7:0] act_set;
    logic       want_on;

    assign act_set = sel_b ? set_high_reg : set_low_reg;
    assign want_on = en_b & act_set[SET_ENABLE_BIT];

    // ------------------------------------------------------------
    // Input over-voltage blanking
    // ------------------------------------------------------------
    logic [15:0] ovp_cnt_reg;
    logic        ovp_trip_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovp_cnt_reg  <= 16'h0000;
            ovp_trip_reg <= 1'b0;
        end else if (!ovp_b) begin
            ovp_cnt_reg  <= 16'h0000;
            ovp_trip_reg <= 1'b0;
        end else if (ovp_cnt_reg >= 16'(OVP_BLANK_CYC - 1)) begin
            ovp_trip_reg <= 1'b1;
        end else begin
            ovp_cnt_reg <= ovp_cnt_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Soft-start and power-ok
    // ------------------------------------------------------------
    logic [31:0] ss_cnt_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ss_cnt_reg <= 32'h0000_0000;
            power_ok_flag_reg  <= 1'b0;
        end else if (!want_on || ovp_trip_reg) begin
            ss_cnt_reg <= 32'h0000_0000;
            power_ok_flag_reg  <= 1'b0;
        end else if (ss_cnt_reg >= 32'(SS_CYCLES - 1)) begin
            power_ok_flag_reg <= 1'b1;
        end else begin
            ss_cnt_reg <= ss_cnt_reg + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Voltage code ramp
    // ------------------------------------------------------------
    // Only rising moves are paced; falling moves take the code at once
    logic [5:0]  code_reg;
    logic [10:0] step_cnt_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code_reg     <= SET_RESET_VAL[5:0];
            step_cnt_reg <= 11'h000;
        end else if (act_set[5:0] <= code_reg) begin
            code_reg     <= act_set[5:0];
            step_cnt_reg <= 11'h000;
        end else if (step_cnt_reg >= step_cycles(slew_reg) - 11'h001) begin
            code_reg     <= code_reg + 6'h01;
            step_cnt_reg <= 11'h000;
        end else begin
            step_cnt_reg <= step_cnt_reg + 11'h001;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            output_on     <= 1'b0;
            forced_pwm    <= 1'b0;
            voltage_code  <= SET_RESET_VAL[5:0];
            discharge_en  <= DISCH_RESET_VAL;
            power_ok_flag <= 1'b0;
        end else begin
            output_on     <= want_on & ~ovp_trip_reg;
            forced_pwm    <= act_set[SET_PWM_BIT];
            voltage_code  <= code_reg;
            discharge_en  <= disch_reg;
            power_ok_flag <= power_ok_flag_reg;
        end
    end

endmodule
